//--- common/acm_defs.vh
// Overview of operation
// - single mode: selector 0..7 picks one input; top bit set prohibited
// - four-scan: codes 0-3 scan from input 0, 4-7 from input 4
// - eight-scan: always from input 0, count is low three bits plus one
// - status bit 4 reads zero, writes ignored
// - trigger field 00: only software start bit write starts conversion
// - trigger 01 pulse timer starts; trigger 10 eight-bit timer starts
// - trigger 11 enables the active-low external trigger pin
// - external pin falling edge sets start bit, then as software start
// - mode field upper bit zero selects single mode, lower bit ignored
// - mode 10 scan_group_size up to four inputs, 11 up to eight
// - time select 00..11 gives 530, 266, 134, 68 states maximum
// - control bits 1 and 0 read zero; register resets to zero
// - each sample resolved by successive approximation to ten bits
// - one write may change channel and set start together; mode needs its own write
// - start begins, clear stops; single mode self-clears, scan stays set
// - end flag after single conversion or whole scan group; irq if enabled
// - result in data register bits 15 to 6, low six read zero
`ifndef ACM_DEFS_VH
`define ACM_DEFS_VH
`define ACM_ADDR_CSR 12'h000
`define ACM_ADDR_CR 12'h004
`define ACM_ADDR_DATA0 12'h010
`define ACM_ADDR_DATA7 12'h02c
`define ACM_CSR_FLAG 7
`define ACM_CSR_IE 6
`define ACM_CSR_START 5
`define ACM_CSR_WMASK 8'h6f
`define ACM_CR_WMASK 8'hfc
`define ACM_CR_RESET 8'h00
`define ACM_TRG_NONE 2'h0
`define ACM_TRG_PTU 2'h1
`define ACM_TRG_TMR8 2'h2
`define ACM_TRG_PIN 2'h3
`define ACM_SAR_BITS 4'ha
`define ACM_T0 10'h212
`define ACM_T1 10'h10a
`define ACM_T2 10'h086
`define ACM_T3 10'h044
`endif

//--- rtl/acm_sar.v
`timescale 1ns/10ps
`include "acm_defs.vh"
// successive approximation engine, one conversion per go pulse
module acm_sar (
  input wire pclk,
  input wire presetn,
  input wire go,
  input wire abort,
  input wire [9:0] conv_time,
  input wire cmp_hi,
  output reg [9:0] dac_code,
  output reg busy,
  output reg done,
  output reg [9:0] result
);
  reg [9:0] cnt_q;
  reg [3:0] bit_q;
  // trial code with the current bit kept or dropped by the comparator
  wire [9:0] kept = cmp_hi ? dac_code : dac_code & ~(10'h200 >> bit_q);
  // comparator answer comes back two edges after a new trial code
  // (registered pin, then the comparator), so each bit takes two states;
  // bits resolve in the last twenty states, earlier ones are sampling
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 10'h000;
      bit_q <= 4'h0;
      dac_code <= 10'h000;
      busy <= 1'b0;
      done <= 1'b0;
      result <= 10'h000;
    end else begin
      done <= 1'b0;
      if (abort) begin
        busy <= 1'b0;
      end else if (go) begin
        busy <= 1'b1;
        cnt_q <= conv_time - 10'h001;
        bit_q <= 4'h0;
        dac_code <= 10'h200;
      end else if (busy) begin
        cnt_q <= cnt_q - 10'h001;
        if (cnt_q <= {5'h00, `ACM_SAR_BITS, 1'b0} && !cnt_q[0]) begin
          if (bit_q != `ACM_SAR_BITS - 4'h1) begin
            bit_q <= bit_q + 4'h1;
            dac_code <= kept | (10'h100 >> bit_q);
          end else begin
            result <= kept;
            busy <= 1'b0;
            done <= 1'b1;
          end
        end
      end
    end
  end
endmodule

//--- rtl/acm_trig.v
`timescale 1ns/10ps
`include "acm_defs.vh"
// selects one hardware start source
module acm_trig (
  input wire pclk,
  input wire presetn,
  input wire [1:0] source,
  input wire ptu_trig,
  input wire tmr8_trig,
  input wire ext_trigger_pin_n,
  output reg fire
);
  reg pin_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_q <= 1'b1;
      fire <= 1'b0;
    end else begin
      pin_q <= ext_trigger_pin_n;
      case (source)
        `ACM_TRG_NONE: fire <= 1'b0;
        `ACM_TRG_PTU: fire <= ptu_trig;
        `ACM_TRG_TMR8: fire <= tmr8_trig;
        `ACM_TRG_PIN: fire <= pin_q & ~ext_trigger_pin_n;
        default: fire <= 1'b0;
      endcase
    end
  end
endmodule

//--- rtl/acm_top.v
// Design decisions made here: the register addresses and the APB slave port.
`timescale 1ns/10ps
`include "acm_defs.vh"
module acm_top (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire ptu_trig,
  input wire tmr8_trig,
  input wire ext_trigger_pin_n,
  input wire cmp_hi,
  output reg [9:0] dac_code_q,
  output reg [2:0] analog_sel_q,
  output reg sample_q,
  output reg conversion_end_interrupt
);
  localparam ST_IDLE = 2'h0;
  localparam ST_RUN = 2'h1;
  localparam ST_WAIT = 2'h2;

  reg [7:0] csr_q;
  reg [7:0] cr_q;
  reg [1:0] st_q;
  reg [2:0] ch_q;
  reg [9:0] res_q [0:7];
  reg sar_go_q;
  wire [9:0] dac;
  wire busy;
  wire done;
  wire [9:0] result;
  wire fire;
  reg [9:0] conv_time;
  reg [2:0] first_ch;
  reg [2:0] last_ch;
  integer i;

  function valid_sel;
    input [3:0] sel;
    begin
      valid_sel = ~sel[3];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////
  acm_trig u_trig (
    .pclk(pclk),
    .presetn(presetn),
    .source(cr_q[7:6]),
    .ptu_trig(ptu_trig),
    .tmr8_trig(tmr8_trig),
    .ext_trigger_pin_n(ext_trigger_pin_n),
    .fire(fire)
  );

  acm_sar u_sar (
    .pclk(pclk),
    .presetn(presetn),
    .go(sar_go_q),
    .abort(~csr_q[`ACM_CSR_START]),
    .conv_time(conv_time),
    .cmp_hi(cmp_hi),
    .dac_code(dac),
    .busy(busy),
    .done(done),
    .result(result)
  );

  ////////////////////////////////////////////////////////////////////
  always @* begin
    case (cr_q[3:2])
      2'h0: conv_time = `ACM_T0;
      2'h1: conv_time = `ACM_T1;
      2'h2: conv_time = `ACM_T2;
      default: conv_time = `ACM_T3;
    endcase
    if (cr_q[5] && !cr_q[4]) begin
      first_ch = {csr_q[2], 2'h0};
      last_ch = {csr_q[2], csr_q[1:0]};
    end else if (cr_q[5]) begin
      first_ch = 3'h0;
      last_ch = csr_q[2:0];
    end else begin
      first_ch = csr_q[2:0];
      last_ch = csr_q[2:0];
    end
  end

  wire acc = psel & penable;
  wire wr = acc & pwrite;
  wire wr_csr = wr & (paddr == `ACM_ADDR_CSR);
  wire wr_cr = wr & (paddr == `ACM_ADDR_CR);
  // eight result words from the data base address, one per input
  wire [11:0] data_off = paddr - `ACM_ADDR_DATA0;
  wire data_hit = paddr >= `ACM_ADDR_DATA0 && paddr <= `ACM_ADDR_DATA7 &&
    paddr[1:0] == 2'h0;
  // start bit rising from software or trigger; written settings are used
  wire [7:0] csr_w = (csr_q & ~`ACM_CSR_WMASK) |
    (pwdata[7:0] & `ACM_CSR_WMASK);
  wire sw_set = wr_csr & pwdata[`ACM_CSR_START] & ~csr_q[`ACM_CSR_START];
  wire hw_set = fire & ~csr_q[`ACM_CSR_START];

  ////////////////////////////////////////////////////////////////////
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      csr_q <= 8'h00;
      cr_q <= `ACM_CR_RESET;
      st_q <= ST_IDLE;
      ch_q <= 3'h0;
      sar_go_q <= 1'b0;
      for (i = 0; i < 8; i = i + 1)
        res_q[i] <= 10'h000;
    end else begin
      sar_go_q <= 1'b0;
      if (wr_cr)
        cr_q <= pwdata[7:0] & `ACM_CR_WMASK;
      if (wr_csr) begin
        csr_q[6:0] <= csr_w[6:0];
        // flag clears only by zero write; hardware set below wins
        if (!pwdata[`ACM_CSR_FLAG])
          csr_q[`ACM_CSR_FLAG] <= 1'b0;
      end
      if (hw_set)
        csr_q[`ACM_CSR_START] <= 1'b1;
      case (st_q)
        ST_IDLE: begin
          if ((sw_set | hw_set) & valid_sel(
              wr_csr ? csr_w[3:0] : csr_q[3:0])) begin
            st_q <= ST_WAIT;
          end else if (sw_set | hw_set) begin
            csr_q[`ACM_CSR_START] <= 1'b0;
          end
        end
        ST_WAIT: begin
          // settings are registered now; begin at group head
          ch_q <= first_ch;
          sar_go_q <= 1'b1;
          st_q <= ST_RUN;
        end
        ST_RUN: begin
          if (!csr_q[`ACM_CSR_START]) begin
            st_q <= ST_IDLE;
          end else if (done) begin
            res_q[ch_q] <= result;
            if (ch_q == last_ch) begin
              csr_q[`ACM_CSR_FLAG] <= 1'b1;
              if (!cr_q[5]) begin
                csr_q[`ACM_CSR_START] <= 1'b0;
                st_q <= ST_IDLE;
              end else begin
                ch_q <= first_ch;
                sar_go_q <= 1'b1;
              end
            end else begin
              ch_q <= ch_q + 3'h1;
              sar_go_q <= 1'b1;
            end
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // zero-wait slave: pready high in every access phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      dac_code_q <= 10'h000;
      analog_sel_q <= 3'h0;
      sample_q <= 1'b0;
      conversion_end_interrupt <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      if (psel & ~penable & ~pwrite) begin
        if (paddr == `ACM_ADDR_CSR)
          prdata <= {24'h000000, csr_q & 8'hef};
        else if (paddr == `ACM_ADDR_CR)
          prdata <= {24'h000000, cr_q};
        else if (data_hit)
          prdata <= {16'h0000, res_q[data_off[4:2]], 6'h00};
        else
          pslverr <= 1'b1;
      end else if (psel & ~penable) begin
        pslverr <= paddr != `ACM_ADDR_CSR && paddr != `ACM_ADDR_CR;
      end
      dac_code_q <= dac;
      analog_sel_q <= ch_q;
      sample_q <= busy;
      conversion_end_interrupt <= csr_q[`ACM_CSR_FLAG] &
        csr_q[`ACM_CSR_IE];
    end
  end
endmodule

//--- tb/acm_analog_model.sv
`timescale 1ns/10ps
// fixed level per input keeps every result predictable
module acm_analog_model (
  input logic [9:0] dac_code_q,
  input logic [2:0] analog_sel_q,
  output logic cmp_hi
);
  assign cmp_hi = {analog_sel_q, 7'h15} >= dac_code_q;
endmodule

//--- tb/acm_monitor.sv
`timescale 1ns/10ps
module acm_monitor (
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [11:0] paddr,
  input logic [31:0] prdata,
  input logic pready,
  input logic pslverr,
  input logic [2:0] analog_sel_q,
  input logic sample_q,
  input logic conversion_end_interrupt
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel && penable && pready;
  wire rd = acc && !pwrite;
  wire dat = paddr >= 12'h010 && paddr <= 12'h02c && paddr[1:0] == 2'h0;
  wire map = paddr == 12'h000 || paddr == 12'h004 || (dat && !pwrite);
  a_ready_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_once: assert property (pready |=> !pready)
    else $error("ready held");
  a_err_map: assert property (acc |-> pslverr == !map)
    else $error("slave error wrong");
  a_err_zero: assert property (rd && pslverr |-> prdata == 32'h0)
    else $error("error read not zero");
  a_csr_bit4: assert property (rd && paddr == 12'h000 |-> !prdata[4])
    else $error("status bit 4 set");
  a_ctl_low: assert property (rd && paddr == 12'h004 |-> !prdata[1:0])
    else $error("control low bits set");
  a_data_low: assert property (rd && dat |-> !prdata[5:0])
    else $error("data low bits set");
  // channel moves two edges after a conversion ends inside a scan
  a_scan_step: assert property ($changed(analog_sel_q) &&
    $past(sample_q, 2) |-> analog_sel_q == $past(analog_sel_q) + 3'h1
    || analog_sel_q[1:0] == 2'h0) else $error("scan order broken");
  c_irq: cover property ($rose(conversion_end_interrupt));
  c_err: cover property (acc && pslverr);
  c_conv: cover property ($rose(sample_q));
endmodule
////////////////////////////////////////////////////////////////
bind acm_top acm_monitor i_mon (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .analog_sel_q(analog_sel_q), .sample_q(sample_q),
  .conversion_end_interrupt(conversion_end_interrupt));

//--- tb/acm_top_tb.sv
`timescale 1ns/10ps
module acm_top_tb;
  typedef struct {logic [11:0] a; logic [7:0] w, x; logic err;} acm_row_t;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
  logic pwrite = 1'h0, ptu_trig = 1'h0, tmr8_trig = 1'h0;
  logic ext_trigger_pin_n = 1'h1, pready, pslverr, cmp_hi, sample_q, irq, e;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic [9:0] dac_code_q;
  logic [2:0] analog_sel_q;
  logic [3:0] m;
  int miscompares = 0, n_tests = 0, cyc = 0;
  acm_row_t rows[4] = '{'{12'h000, 8'h5f, 8'h4f, 1'h0},
    '{12'h004, 8'hff, 8'hfc, 1'h0}, '{12'h004, 8'h0c, 8'h0c, 1'h0},
    '{12'h100, 8'hff, 8'h00, 1'h1}};
  acm_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ptu_trig(ptu_trig), .tmr8_trig(tmr8_trig),
    .ext_trigger_pin_n(ext_trigger_pin_n), .cmp_hi(cmp_hi),
    .dac_code_q(dac_code_q), .analog_sel_q(analog_sel_q),
    .sample_q(sample_q), .conversion_end_interrupt(irq));
  acm_analog_model i_ana (.dac_code_q(dac_code_q),
    .analog_sel_q(analog_sel_q), .cmp_hi(cmp_hi));
  initial forever #25 pclk = ~pclk;
  ////////////////////////////////////////////////////////////////
  task end_sim;
    $display("tests %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] x);
    n_tests++;
    if (g !== x) begin
      miscompares++;
      $display("CHECK FAILED %0t got %h exp %h", $time, g, x);
    end
  endtask
  task apb(input logic [11:0] a, input logic w, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    paddr <= a;
    pwrite <= w;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task wait_flag;
    repeat (300) begin
      apb(12'h000, 1'h0, 8'h00);
      if (r[7] === 1'h1) break;
    end
  endtask
  task chk_data(input logic [2:0] ch);
    apb({7'h0, ch, 2'h0} + 12'h010, 1'h0, 8'h00);
    chk(r, {16'h0, ch, 7'h15, 6'h0});
  endtask
  // one-cycle pulses; pin pulse is a falling then rising edge
  task pulse(input logic [2:0] p);
    @(posedge pclk);
    ptu_trig <= p[0];
    tmr8_trig <= p[1];
    ext_trigger_pin_n <= ~p[2];
    @(posedge pclk);
    ptu_trig <= 1'h0;
    tmr8_trig <= 1'h0;
    ext_trigger_pin_n <= 1'h1;
    repeat (3) @(posedge pclk);
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 40000) begin
      miscompares++;
      end_sim;
    end
  end
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    apb(12'h000, 1'h0, 8'h00);
    chk(r, 32'h0);
    apb(12'h004, 1'h0, 8'h00);
    chk(r, 32'h0);
    foreach (rows[i]) begin
      apb(rows[i].a, 1'h1, rows[i].w);
      apb(rows[i].a, 1'h0, 8'h00);
      chk(r, {24'h0, rows[i].x});
      chk({31'h0, e}, {31'h0, rows[i].err});
    end
    apb(12'h000, 1'h1, 8'h66);
    wait_flag;
    chk(r, 32'hc6);
    chk({31'h0, irq}, 32'h1);
    chk_data(3'h6);
    apb(12'h000, 1'h1, 8'h28);
    apb(12'h000, 1'h0, 8'h00);
    chk(r, 32'h08);
    chk({31'h0, irq}, 32'h0);
    for (int s = 0; s < 4; s++) begin
      m = 4'h1 << s >> 1;
      apb(12'h004, 1'h1, {s[1:0], 6'h0c});
      apb(12'h000, 1'h1, {5'h0, s[2:0]});
      pulse(~m[2:0]);
      apb(12'h000, 1'h0, 8'h00);
      chk(r, {29'h0, s[2:0]});
      if (s > 0) begin
        pulse(m[2:0]);
        wait_flag;
        chk(r, {24'h0, 5'h10, s[2:0]});
        chk_data(s[2:0]);
      end
    end
    for (int k = 0; k < 2; k++) begin
      apb(12'h004, 1'h1, k ? 8'h3c : 8'h2c);
      apb(12'h000, 1'h1, k ? 8'h22 : 8'h26);
      wait_flag;
      chk(r, k ? 32'ha2 : 32'ha6);
      for (int c = 0; c < 3; c++)
        chk_data(c[2:0] + (k ? 3'h0 : 3'h4));
      apb(12'h000, 1'h1, 8'h00);
      apb(12'h000, 1'h0, 8'h00);
      chk(r, 32'h0);
    end
    // reset in the middle of a running scan
    apb(12'h000, 1'h1, 8'h26);
    repeat (100) @(posedge pclk);
    presetn <= 1'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    chk({31'h0, sample_q}, 32'h0);
    apb(12'h000, 1'h0, 8'h00);
    chk(r, 32'h0);
    apb(12'h004, 1'h0, 8'h00);
    chk(r, 32'h0);
    end_sim;
  end
endmodule
